// >>> core/eag_core.sv
// extended address generation: mode select, effective address build,
// chip enable decode and extra-cycle flags, registers on AHB-Lite
// assumes core requests are synchronous to hclk, one per cycle at most
`timescale 1ns/1ns
`default_nettype none

// Operation
// - reset always returns to 16-bit mode
// - two-bit field selects addressing mode
// - 16-bit mode reaches only 64kB each
// - paged mode: calls and returns one extra
// - paged mode: interrupt response one cycle longer
// - paged mode: vectors fetched from lowest page
// - contiguous mode: full 22-bit program counter saved
// - contiguous mode: branches use 22-bit forms
// - contiguous mode: pointer increment one extra cycle
// - 22 bits select memory, bit 22 maps SRAM
// - first pointer move uses upper, high, low
// - second pointer move uses its three bytes
// - indexed move: upper byte, port latch, index
// - paged fetch takes bits 23-16 from bank
// - 10-bit stack: high byte, then low pointer
// - 20-bit bus, four program, four data enables
// - three internal memories: 256, 4k, 512 bytes
module eag_core (
	// clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// ahb-lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	// core address request
	input  wire logic              req_valid,
	input  wire eag_pkg::eag_kind_t req_kind,
	input  wire eag_pkg::eag_op_t  req_op,
	input  wire logic [21:0]       req_pc,
	input  wire logic [7:0]        req_index,
	// address answer
	output logic                   ans_valid,
	output logic [23:0]            ans_addr,
	output logic [19:0]            mem_addr,
	output logic [3:0]             prog_ce_n,
	output logic [3:0]             data_pe_n,
	output logic                   int_sram_sel,
	output logic                   extra_cycle,
	output logic                   wide_form
);

	logic [7:0]          reg_file [eag_pkg::NUM_REGS];
	logic [eag_pkg::NUM_REGS-1:0] rd_hit;
	logic [eag_pkg::NUM_REGS-1:0] wr_hit;
	logic [7:0]          rd_idx;
	logic                addr_ok;
	logic                rd_req;
	logic                wr_req;
	logic                wr_pend;
	logic [7:0]          wr_idx;
	logic [7:0]          rd_val;
	logic [7:0]          status;
	eag_pkg::eag_mode_t  mode;
	logic [23:0]         next_ea;
	logic                next_sram;
	logic                next_extra;
	logic                next_wide;
	logic [3:0]          chip_sel_n;
	logic                is_prog;
	logic                is_data;

	// ---------------- bus decode ----------------
	assign rd_idx  = haddr[eag_pkg::IDX_MSB:eag_pkg::IDX_LSB];
	assign addr_ok = (haddr[31:eag_pkg::IDX_MSB+1] == '0);
	assign rd_req  = hsel && hready && (htrans == eag_pkg::HTRANS_NSEQ)
		&& !hwrite && addr_ok;
	assign wr_req  = hsel && hready && (htrans == eag_pkg::HTRANS_NSEQ)
		&& hwrite && addr_ok;

	// per-register decode of the read index and pending write index
	genvar gi;
	generate
		for (gi = 0; gi < eag_pkg::NUM_REGS; gi++) begin : g_dec
			assign rd_hit[gi] = (rd_idx == eag_pkg::REG_IDX[gi]);
			assign wr_hit[gi] = wr_pend && (wr_idx == eag_pkg::REG_IDX[gi])
				&& (gi != eag_pkg::R_STAT);
		end
	endgenerate

	// status: decoded mode and whether last answer hit internal SRAM
	assign status = {5'h00, int_sram_sel, mode};

	// read mux; a write still in its data phase is forwarded so that
	// a read right behind it sees the new value
	always_comb begin
		rd_val = eag_pkg::REG_RESET;
		for (int i = 0; i < eag_pkg::NUM_REGS; i++) begin
			if (rd_hit[i]) begin
				if (i == eag_pkg::R_STAT)
					rd_val = status;
				else if (wr_hit[i])
					rd_val = hwdata[7:0];
				else
					rd_val = reg_file[i];
			end
		end
	end

	// zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= '0;
		else if (rd_req)
			hrdata <= {24'h000000, rd_val};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_idx  <= eag_pkg::REG_RESET;
		end else if (hready) begin
			wr_pend <= wr_req;
			wr_idx  <= rd_idx;
		end
	end

	generate
		for (gi = 0; gi < eag_pkg::NUM_REGS; gi++) begin : g_reg
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn)
					reg_file[gi] <= eag_pkg::REG_RESET;
				else if (wr_hit[gi])
					reg_file[gi] <= hwdata[7:0];
			end
		end
	endgenerate

	// ---------------- mode ----------------
	// mode field decode
	always_comb begin
		case (reg_file[eag_pkg::R_CTRL][eag_pkg::MODE_LSB +: 2])
			eag_pkg::SEL_PAGED:  mode = eag_pkg::EAG_PAGED;
			eag_pkg::SEL_CONTIG: mode = eag_pkg::EAG_CONTIG;
			// reserved code falls back to the safe 16-bit map
			default:             mode = eag_pkg::EAG_M16;
		endcase
	end

	// ---------------- effective address ----------------
	always_comb begin
		next_ea = 24'h000000;
		case (req_kind)
			eag_pkg::KIND_FETCH: begin
				if (mode == eag_pkg::EAG_PAGED)
					next_ea = {reg_file[eag_pkg::R_BANK], req_pc[15:0]};
				else if (mode == eag_pkg::EAG_CONTIG)
					next_ea = {2'b00, req_pc};
				else
					next_ea = {8'h00, req_pc[15:0]};
			end
			eag_pkg::KIND_VECTOR: begin
				if (mode == eag_pkg::EAG_PAGED)
					next_ea = {16'h0000, req_pc[7:0]};
				else if (mode == eag_pkg::EAG_CONTIG)
					next_ea = {2'b00, req_pc};
				else
					next_ea = {8'h00, req_pc[15:0]};
			end
			eag_pkg::KIND_XMOV_P0:
				next_ea = {reg_file[eag_pkg::R_PTR0U],
					reg_file[eag_pkg::R_PTR0H], reg_file[eag_pkg::R_PTR0L]};
			eag_pkg::KIND_XMOV_P1:
				next_ea = {reg_file[eag_pkg::R_PTR1U],
					reg_file[eag_pkg::R_PTR1H], reg_file[eag_pkg::R_PTR1L]};
			eag_pkg::KIND_XMOV_IX:
				next_ea = {reg_file[eag_pkg::R_MXU], reg_file[eag_pkg::R_PLAT],
					req_index};
			eag_pkg::KIND_STACK: begin
				if (reg_file[eag_pkg::R_CTRL][eag_pkg::STACK10_BIT])
					next_ea = {8'h00, reg_file[eag_pkg::R_STKH],
						reg_file[eag_pkg::R_STKL]};
				else
					next_ea = {16'h0000, reg_file[eag_pkg::R_STKL]};
			end
			default: next_ea = 24'h000000;
		endcase
		if (mode == eag_pkg::EAG_M16)
			next_ea[23:16] = 8'h00;
	end

	// 4k SRAM window
	// the first 4kB above the space is backed (bit 23 is not decoded, so its image at bit 23 set also hits), the rest is external
	assign next_sram = next_ea[eag_pkg::SRAM_BIT]
		&& (next_ea[eag_pkg::SEL_W-1:eag_pkg::SRAM_AW] == '0);

	assign is_prog = (req_kind == eag_pkg::KIND_FETCH)
		|| (req_kind == eag_pkg::KIND_VECTOR);
	assign is_data = (req_kind == eag_pkg::KIND_XMOV_P0)
		|| (req_kind == eag_pkg::KIND_XMOV_P1)
		|| (req_kind == eag_pkg::KIND_XMOV_IX);

	assign chip_sel_n = ~(4'h1 << next_ea[eag_pkg::CHIP_LSB +: 2]);

	always_comb begin
		next_extra = 1'b0;
		next_wide  = 1'b0;
		case (mode)
			eag_pkg::EAG_PAGED:
				next_extra = (req_op == eag_pkg::OP_CALL_RET)
					|| (req_op == eag_pkg::OP_IRQ);
			eag_pkg::EAG_CONTIG: begin
				next_extra = (req_op == eag_pkg::OP_INC_DP);
				next_wide  = (req_op == eag_pkg::OP_CALL_RET)
					|| (req_op == eag_pkg::OP_LONG_BRANCH);
			end
			default: begin
				next_extra = 1'b0;
				next_wide  = 1'b0;
			end
		endcase
	end

	// answer registers, one cycle behind the request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ans_valid    <= 1'b0;
			ans_addr     <= 24'h000000;
			mem_addr     <= '0;
			int_sram_sel <= 1'b0;
			extra_cycle  <= 1'b0;
			wide_form    <= 1'b0;
		end else begin
			ans_valid <= req_valid;
			if (req_valid) begin
				ans_addr     <= next_ea;
				mem_addr     <= next_ea[eag_pkg::MEM_AW-1:0];
				int_sram_sel <= next_sram;
				extra_cycle  <= next_extra;
				wide_form    <= next_wide;
			end
		end
	end

	// enables fall back to idle between answers; internal hits stay off bus
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prog_ce_n <= 4'hf;
			data_pe_n <= 4'hf;
		end else begin
			prog_ce_n <= (req_valid && is_prog && !next_sram)
				? chip_sel_n : 4'hf;
			data_pe_n <= (req_valid && is_data && !next_sram)
				? chip_sel_n : 4'hf;
		end
	end

	// ---------------- assertions ----------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_req_in(eag_pkg::eag_mode_t m);
		req_valid && mode == m;
	endsequence

	a_reset_mode16: assert property (
		$rose(hresetn) |-> mode == eag_pkg::EAG_M16)
		else $error("mode not 16-bit after reset");
	a_mode_select: assert property (
		reg_file[eag_pkg::R_CTRL][1:0] == eag_pkg::SEL_PAGED
			|-> mode == eag_pkg::EAG_PAGED)
		else $error("mode field not honoured");
	a_m16_upper: assert property (
		s_req_in(eag_pkg::EAG_M16) ##1 ans_valid |-> ans_addr[23:16] == 8'h00)
		else $error("upper bits set in 16-bit mode");
	a_first_ptr: assert property (
		s_req_in(eag_pkg::EAG_CONTIG) and req_kind == eag_pkg::KIND_XMOV_P0
		|=> ans_addr == {$past(reg_file[eag_pkg::R_PTR0U]),
			$past(reg_file[eag_pkg::R_PTR0H]),
			$past(reg_file[eag_pkg::R_PTR0L])})
		else $error("first pointer address wrong");
	a_second_ptr: assert property (
		s_req_in(eag_pkg::EAG_PAGED) and req_kind == eag_pkg::KIND_XMOV_P1
		|=> ans_addr == {$past(reg_file[eag_pkg::R_PTR1U]),
			$past(reg_file[eag_pkg::R_PTR1H]),
			$past(reg_file[eag_pkg::R_PTR1L])})
		else $error("second pointer address wrong");
	a_index_move: assert property (
		req_valid && req_kind == eag_pkg::KIND_XMOV_IX
		|=> ans_addr[15:0] == {$past(reg_file[eag_pkg::R_PLAT]),
			$past(req_index)})
		else $error("indexed move address wrong");
	a_paged_bank: assert property (
		s_req_in(eag_pkg::EAG_PAGED) and req_kind == eag_pkg::KIND_FETCH
		|=> ans_addr[23:16] == $past(reg_file[eag_pkg::R_BANK]))
		else $error("paged fetch bank wrong");
	a_vector_page: assert property (
		s_req_in(eag_pkg::EAG_PAGED) and req_kind == eag_pkg::KIND_VECTOR
		|=> ans_addr[23:8] == 16'h0000)
		else $error("vector outside lowest page");
	a_paged_extra: assert property (
		s_req_in(eag_pkg::EAG_PAGED) and req_op == eag_pkg::OP_CALL_RET
		|=> extra_cycle)
		else $error("paged call lacks extra cycle");
	a_contig_incdp: assert property (
		s_req_in(eag_pkg::EAG_CONTIG) and req_op == eag_pkg::OP_INC_DP
		|=> extra_cycle && !wide_form)
		else $error("pointer increment timing wrong");
	a_one_enable: assert property (
		ans_valid && prog_ce_n != 4'hf |-> $onehot(~prog_ce_n)
			&& !int_sram_sel && data_pe_n == 4'hf)
		else $error("program enables not one-hot");
	a_irq_extra: assert property (
		s_req_in(eag_pkg::EAG_PAGED) and req_op == eag_pkg::OP_IRQ
		|=> extra_cycle)
		else $error("paged interrupt lacks extra cycle");
	a_m16_timing: assert property (
		s_req_in(eag_pkg::EAG_M16) |=> !extra_cycle && !wide_form)
		else $error("16-bit mode timing changed");
	a_contig_pc: assert property (
		s_req_in(eag_pkg::EAG_CONTIG) and req_kind == eag_pkg::KIND_FETCH
		|=> ans_addr == {2'b00, $past(req_pc)})
		else $error("contiguous fetch lost counter bits");
	a_wide_branch: assert property (
		s_req_in(eag_pkg::EAG_CONTIG) and req_op == eag_pkg::OP_LONG_BRANCH
		|=> wide_form && !extra_cycle)
		else $error("long branch not in wide form");
	a_ten_stack: assert property (
		req_valid && req_kind == eag_pkg::KIND_STACK
			&& reg_file[eag_pkg::R_CTRL][eag_pkg::STACK10_BIT]
		|=> ans_addr[15:0] == {$past(reg_file[eag_pkg::R_STKH]),
			$past(reg_file[eag_pkg::R_STKL])})
		else $error("ten-bit stack address wrong");
	a_sram_quiet: assert property (
		ans_valid && int_sram_sel |-> ans_addr[eag_pkg::SRAM_BIT]
			&& prog_ce_n == 4'hf && data_pe_n == 4'hf)
		else $error("internal SRAM hit drove the bus");
	a_data_enable: assert property (
		ans_valid && data_pe_n != 4'hf |-> $onehot(~data_pe_n)
			&& prog_ce_n == 4'hf)
		else $error("data enables not one-hot");
	a_enables_idle: assert property (
		!ans_valid |-> prog_ce_n == 4'hf && data_pe_n == 4'hf)
		else $error("enable active outside an answer");

endmodule // eag_core

`default_nettype wire

// >>> core/eag_pkg.sv
// extended address generation: shared constants and types
// assumes a 32-bit AHB-Lite register bus and one core clock
package eag_pkg;

	// register indices; byte address is four times the index
	localparam int        NUM_REGS = 13;
	localparam logic [7:0] IDX_STKL  = 8'h81;
	localparam logic [7:0] IDX_PTR0L = 8'h82;
	localparam logic [7:0] IDX_PTR0H = 8'h83;
	localparam logic [7:0] IDX_PTR1L = 8'h84;
	localparam logic [7:0] IDX_PTR1H = 8'h85;
	localparam logic [7:0] IDX_PTR0U = 8'h93;
	localparam logic [7:0] IDX_PTR1U = 8'h95;
	localparam logic [7:0] IDX_STKH  = 8'h9b;
	localparam logic [7:0] IDX_BANK  = 8'h9c;
	localparam logic [7:0] IDX_PLAT  = 8'ha0;
	localparam logic [7:0] IDX_MXU   = 8'hea;
	localparam logic [7:0] IDX_CTRL  = 8'hf0;
	localparam logic [7:0] IDX_STAT  = 8'hf1;
	localparam logic [7:0] REG_IDX [NUM_REGS] = '{IDX_STKL, IDX_PTR0L,
		IDX_PTR0H, IDX_PTR1L, IDX_PTR1H, IDX_PTR0U, IDX_PTR1U, IDX_STKH,
		IDX_BANK, IDX_PLAT, IDX_MXU, IDX_CTRL, IDX_STAT};
	// slot of each register in the register array
	localparam int R_STKL = 0, R_PTR0L = 1, R_PTR0H = 2, R_PTR1L = 3;
	localparam int R_PTR1H = 4, R_PTR0U = 5, R_PTR1U = 6, R_STKH = 7;
	localparam int R_BANK = 8, R_PLAT = 9, R_MXU = 10, R_CTRL = 11;
	localparam int R_STAT = 12;
	localparam logic [7:0] REG_RESET = 8'h00;

	// address control register fields
	localparam int         MODE_LSB    = 0;
	localparam int         STACK10_BIT = 2;
	localparam logic [1:0] SEL_M16     = 2'h0;
	localparam logic [1:0] SEL_PAGED   = 2'h1;
	localparam logic [1:0] SEL_CONTIG  = 2'h2;

	// bus decode
	localparam int         IDX_LSB     = 2;
	localparam int         IDX_MSB     = 9;
	localparam logic [1:0] HTRANS_NSEQ = 2'h2;

	// address map
	localparam int MEM_AW   = 20;
	localparam int SEL_W    = 22;
	localparam int SRAM_BIT = 22;
	localparam int SRAM_AW  = 12;
	localparam int CHIP_LSB = 20;
	localparam int SCRATCH_BYTES = 256;
	localparam int SRAM_BYTES    = 4096;
	localparam int MSG_BYTES     = 512;

	typedef enum logic [1:0] {EAG_M16, EAG_PAGED, EAG_CONTIG} eag_mode_t;
	typedef enum logic [2:0] {KIND_FETCH, KIND_VECTOR, KIND_XMOV_P0,
		KIND_XMOV_P1, KIND_XMOV_IX, KIND_STACK} eag_kind_t;
	typedef enum logic [2:0] {OP_PLAIN, OP_CALL_RET, OP_IRQ, OP_INC_DP,
		OP_LONG_BRANCH} eag_op_t;

endpackage

// >>> verification/eag_ext_mem.sv
// external memory model on the 20-bit address bus
// assumes enables are active low and valid in the answer cycle
`timescale 1ns/1ns
`default_nettype none
module eag_ext_mem (
	// bus from the address block
	input  wire logic [19:0] mem_addr,
	input  wire logic [3:0]  prog_ce_n,
	input  wire logic [3:0]  data_pe_n,
	// data back to the core side
	output logic      [7:0]  rd_data
);
	logic [7:0] last;

	// released bus shows the inverse, never a stale value
	always @(mem_addr or prog_ce_n or data_pe_n) begin
		if (&{prog_ce_n, data_pe_n}) begin
			rd_data = ~last;
		end else begin
			last = mem_addr[7:0] ^ 8'h5a;
			rd_data = last;
		end
	end
endmodule // eag_ext_mem
`default_nettype wire

// >>> verification/test_extended_address_generation.sv
// bench for the extended address block: registers and address requests
// assumes a zero-wait AHB-Lite slave and one core clock
`timescale 1ns/1ns
`default_nettype none
module test_extended_address_generation;
	logic               hclk, hresetn, hsel, hwrite, hready, hresp;
	logic        [31:0] haddr, hwdata, hrdata, rd;
	logic        [1:0]  htrans;
	logic        [2:0]  hsize;
	logic               hreadyout, req_valid, ans_valid, int_sram_sel;
	logic               extra_cycle, wide_form;
	eag_pkg::eag_kind_t req_kind;
	eag_pkg::eag_op_t   req_op;
	logic        [21:0] req_pc;
	logic        [7:0]  req_index, ext_data;
	logic        [23:0] ans_addr;
	logic        [19:0] mem_addr;
	logic        [3:0]  prog_ce_n, data_pe_n;
	int                 bad_count, cmp_count;

	// short aliases keep scenario lines within the line width
	localparam eag_pkg::eag_kind_t K_FE = eag_pkg::KIND_FETCH;
	localparam eag_pkg::eag_kind_t K_VE = eag_pkg::KIND_VECTOR;
	localparam eag_pkg::eag_kind_t K_X0 = eag_pkg::KIND_XMOV_P0;
	localparam eag_pkg::eag_kind_t K_X1 = eag_pkg::KIND_XMOV_P1;
	localparam eag_pkg::eag_kind_t K_XI = eag_pkg::KIND_XMOV_IX;
	localparam eag_pkg::eag_kind_t K_ST = eag_pkg::KIND_STACK;
	localparam eag_pkg::eag_op_t   O_PL = eag_pkg::OP_PLAIN;
	localparam eag_pkg::eag_op_t   O_CR = eag_pkg::OP_CALL_RET;
	localparam eag_pkg::eag_op_t   O_IR = eag_pkg::OP_IRQ;
	localparam eag_pkg::eag_op_t   O_ID = eag_pkg::OP_INC_DP;
	localparam eag_pkg::eag_op_t   O_LB = eag_pkg::OP_LONG_BRANCH;

	assign hready = hreadyout;
	eag_core DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .req_valid(req_valid),
		.req_kind(req_kind), .req_op(req_op), .req_pc(req_pc),
		.req_index(req_index), .ans_valid(ans_valid), .ans_addr(ans_addr),
		.mem_addr(mem_addr), .prog_ce_n(prog_ce_n), .data_pe_n(data_pe_n),
		.int_sram_sel(int_sram_sel), .extra_cycle(extra_cycle),
		.wide_form(wide_form));
	eag_ext_mem mem (.mem_addr(mem_addr), .prog_ce_n(prog_ce_n),
		.data_pe_n(data_pe_n), .rd_data(ext_data));

	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	task chk(input string what, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// address phase then data phase, each held until hready
	task automatic ahb(input logic w, input logic [7:0] ix,
		input logic [31:0] wd);
		int n;
		haddr  <= {22'h0, ix, 2'h0};
		hwrite <= w;
		htrans <= eag_pkg::HTRANS_NSEQ;
		for (int p = 0; p < 2; p++) begin
			n = 0;
			do begin
				@(posedge hclk);
				n++;
			end while (hreadyout !== 1'b1 && n < 20);
			if (hreadyout !== 1'b1) begin
				bad_count++;
				finish_test();
			end
			htrans <= 2'h0;
			hwdata <= wd;
		end
		chk("hresp", {31'h0, hresp}, 32'h0);
		rd = hrdata;
	endtask

	task wr(input logic [7:0] ix, input logic [7:0] d);
		ahb(1'b1, ix, {24'h0, d});
	endtask

	task rdc(input string nm, input logic [7:0] ix, input logic [7:0] e);
		ahb(1'b0, ix, 32'h0);
		chk(nm, rd, {24'h0, e});
	endtask

	// one request, answer checked in its single valid cycle
	task automatic rq(input eag_pkg::eag_kind_t k,
		input eag_pkg::eag_op_t o, input logic [21:0] pc,
		input logic [7:0] ix, input logic [23:0] ea, input logic ex, wf);
		logic       sr;
		logic [3:0] oh;
		sr = (ea[23:12] === 12'h400);
		oh = ~(4'h1 << ea[21:20]);
		req_valid <= 1'b1;
		req_kind  <= k;
		req_op    <= o;
		req_pc    <= pc;
		req_index <= ix;
		@(posedge hclk);
		req_valid <= 1'b0;
		#1;
		chk("ans_valid", {31'h0, ans_valid}, 32'h1);
		chk("ans_addr", {8'h0, ans_addr}, {8'h0, ea});
		chk("mem_addr", {12'h0, mem_addr}, {12'h0, ea[19:0]});
		chk("sram", {31'h0, int_sram_sel}, {31'h0, sr});
		chk("extra", {31'h0, extra_cycle}, {31'h0, ex});
		chk("wide", {31'h0, wide_form}, {31'h0, wf});
		chk("prog_ce_n", {28'h0, prog_ce_n}, {28'h0,
			(!sr && k <= eag_pkg::KIND_VECTOR) ? oh : 4'hf});
		chk("data_pe_n", {28'h0, data_pe_n}, {28'h0, (!sr &&
			k >= eag_pkg::KIND_XMOV_P0 && k <= eag_pkg::KIND_XMOV_IX) ?
			oh : 4'hf});
		if (!sr && k != eag_pkg::KIND_STACK)
			chk("bus data", {24'h0, ext_data}, {24'h0, ea[7:0] ^ 8'h5a});
		@(posedge hclk);
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		req_valid = 1'b0;
		req_kind = eag_pkg::KIND_FETCH;
		req_op = eag_pkg::OP_PLAIN;
		req_pc = 22'h0;
		req_index = 8'h0;
		bad_count = 0;
		cmp_count = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc("mode", eag_pkg::IDX_CTRL, 8'h00);
		rdc("status", eag_pkg::IDX_STAT, 8'h00);
		wr(eag_pkg::IDX_PTR0L, 8'h12);
		wr(eag_pkg::IDX_PTR0H, 8'h34);
		wr(eag_pkg::IDX_PTR0U, 8'h56);
		wr(eag_pkg::IDX_PTR1L, 8'h78);
		wr(eag_pkg::IDX_PTR1H, 8'h9a);
		wr(eag_pkg::IDX_PTR1U, 8'h2b);
		wr(eag_pkg::IDX_STKH, 8'h03);
		wr(eag_pkg::IDX_STKL, 8'hc4);
		wr(eag_pkg::IDX_BANK, 8'h3d);
		wr(eag_pkg::IDX_PLAT, 8'he5);
		wr(eag_pkg::IDX_MXU, 8'h17);
		rdc("upper", eag_pkg::IDX_PTR0U, 8'h56);
		wr(8'h00, 8'hff);
		rdc("unmapped", 8'h00, 8'h00);
		wr(eag_pkg::IDX_STAT, 8'h03);
		rdc("status", eag_pkg::IDX_STAT, 8'h00);
		$display("test registers done");
		rq(K_X0, O_ID, 22'h0, 8'h0, 24'h003412, 1'b0, 1'b0);
		rq(K_FE, O_CR, 22'h3abcde, 8'h0, 24'h00bcde, 1'b0, 1'b0);
		rq(K_VE, O_IR, 22'h3abcde, 8'h0, 24'h00bcde, 1'b0, 1'b0);
		rq(K_ST, O_PL, 22'h0, 8'h0, 24'h0000c4, 1'b0, 1'b0);
		$display("test 16-bit done");
		wr(eag_pkg::IDX_CTRL, 8'h01);
		rdc("status", eag_pkg::IDX_STAT, 8'h01);
		rq(K_FE, O_CR, 22'h012345, 8'h0, 24'h3d2345, 1'b1, 1'b0);
		rq(K_VE, O_IR, 22'h1234ab, 8'h0, 24'h0000ab, 1'b1, 1'b0);
		rq(K_XI, O_ID, 22'h0, 8'h66, 24'h17e566, 1'b0, 1'b0);
		rq(K_X1, O_PL, 22'h0, 8'h0, 24'h2b9a78, 1'b0, 1'b0);
		$display("test paged done");
		wr(eag_pkg::IDX_CTRL, 8'h06);
		rdc("status", eag_pkg::IDX_STAT, 8'h02);
		rq(K_FE, O_LB, 22'h2abcde, 8'h0, 24'h2abcde, 1'b0, 1'b1);
		rq(K_FE, O_CR, 22'h1fffff, 8'h0, 24'h1fffff, 1'b0, 1'b1);
		rq(K_X0, O_ID, 22'h0, 8'h0, 24'h563412, 1'b1, 1'b0);
		rq(K_X1, O_PL, 22'h0, 8'h0, 24'h2b9a78, 1'b0, 1'b0);
		rq(K_XI, O_PL, 22'h0, 8'h66, 24'h17e566, 1'b0, 1'b0);
		rq(K_ST, O_PL, 22'h0, 8'h0, 24'h0003c4, 1'b0, 1'b0);
		wr(eag_pkg::IDX_CTRL, 8'h03);
		rq(K_X0, O_PL, 22'h0, 8'h0, 24'h003412, 1'b0, 1'b0);
		$display("test contiguous done");
		wr(eag_pkg::IDX_CTRL, 8'h02);
		wr(eag_pkg::IDX_PTR0U, 8'h40);
		wr(eag_pkg::IDX_PTR0H, 8'h00);
		wr(eag_pkg::IDX_PTR0L, 8'h10);
		rq(K_X0, O_PL, 22'h0, 8'h0, 24'h400010, 1'b0, 1'b0);
		rdc("status", eag_pkg::IDX_STAT, 8'h06);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc("mode", eag_pkg::IDX_CTRL, 8'h00);
		$display("test sram and reset done");
		finish_test();
	end
endmodule // test_extended_address_generation
`default_nettype wire
